// >>> verif/slfc_frame_ctrl_tb_top.sv
// Self-checking bench for the serial link frame control block.
`timescale 1ns/1ps
module slfc_frame_ctrl_tb_top;
    import slfc_pkg::*;
    logic clk, rstn, reg_wr, reg_rd, rx_byte_valid, tx_byte_sent, link_error, hdr_id_ok;
    logic [1:0] reg_addr, hdr_len_code;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic tx_byte_req, tx_is_checksum, hdr_tx_start, hdr_rx_arm, link_enable, crc_on;
    logic timeout_on, listen_on, parity_en, parity_odd, uart_rx_en, uart_tx_en;
    logic [3:0] lt [4] = '{4'h2, 4'h2, 4'h4, 4'h8};
    int n_fail = 0;
    int n_tests = 0;
    int n_htx = 0;
    int n_hrx = 0;
    int n_sent = 0;
    int h0;

    slfc_frame_ctrl DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_byte_valid(rx_byte_valid),
        .tx_byte_sent(tx_byte_sent), .link_error(link_error), .hdr_id_ok(hdr_id_ok),
        .hdr_len_code(hdr_len_code), .tx_byte_req(tx_byte_req), .tx_is_checksum(tx_is_checksum),
        .hdr_tx_start(hdr_tx_start), .hdr_rx_arm(hdr_rx_arm), .link_enable(link_enable),
        .crc_on(crc_on), .timeout_on(timeout_on), .listen_on(listen_on), .parity_en(parity_en),
        .parity_odd(parity_odd), .uart_rx_en(uart_rx_en), .uart_tx_en(uart_tx_en));

    slfc_peer_model u_peer (.clk(clk), .rstn(rstn), .tx_byte_req(tx_byte_req),
        .tx_is_checksum(tx_is_checksum), .rx_byte_valid(rx_byte_valid),
        .tx_byte_sent(tx_byte_sent), .link_error(link_error), .hdr_id_ok(hdr_id_ok),
        .hdr_len_code(hdr_len_code));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        n_htx <= n_htx + int'(hdr_tx_start === 1'b1);
        n_hrx <= n_hrx + int'(hdr_rx_arm === 1'b1);
        n_sent <= n_sent + int'(tx_byte_sent === 1'b1);
    end

    task automatic tally_and_finish;
        $display("Checks made: %0d, mismatches: %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rchk(input string nm, input logic [1:0] a, input logic [7:0] exp);
        rd(a);
        chk(nm, exp, d);
    endtask

    // Polls busy; the poll reads themselves are not counted as checks.
    task automatic wait_idle;
        int k;
        for (k = 0; k < 300; k++) begin
            rd(SLFC_ADDR_STAT);
            if (d[SLFC_STAT_BUSY] === 1'b0) break;
        end
        if (k == 300) begin
            n_fail++;
            $display("[ERR] busy expected 0 seen 1");
            tally_and_finish();
        end
    endtask

    task automatic tx_run(input logic [7:0] lw, input int g, input int e,
        input logic [7:0] el, input logic [7:0] es, input int ns);
        u_peer.gap = g;
        u_peer.tx_err_at = e;
        u_peer.n_cks = 0;
        h0 = n_sent;
        wr(SLFC_ADDR_LEN, lw);
        wr(SLFC_ADDR_CTRL, 8'h0b);
        wait_idle();
        rchk("tx len", SLFC_ADDR_LEN, el);
        rchk("tx stat", SLFC_ADDR_STAT, es);
        chk("tx bytes", 8'(ns), 8'(n_sent - h0));
        chk("tx cks", 8'(e < 0), 8'(u_peer.n_cks));
        wr(SLFC_ADDR_STAT, 8'h0f);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        $display("[ERR] run time expected done seen hang");
        tally_and_finish();
    end

    initial begin
        rstn = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rchk("ctrl reset", SLFC_ADDR_CTRL, SLFC_CTRL_RESET);
        rchk("len reset", SLFC_ADDR_LEN, 8'h00);
        rchk("stat reset", SLFC_ADDR_STAT, 8'h00);
        chk("cfg reset", 8'h03, {6'h0, crc_on, timeout_on});
        wr(2'h3, 8'hff);
        rchk("unmapped", 2'h3, 8'h00);
        @(posedge clk);
        #1 chk("rdata idle", 8'h00, reg_rdata);
        h0 = n_htx;
        wr(SLFC_ADDR_CTRL, 8'h01);
        repeat (3) @(posedge clk);
        chk("hdr tx off", 8'(h0), 8'(n_htx));
        chk("enable off", 8'h00, {7'h0, link_enable});
        wr(SLFC_ADDR_CTRL, 8'h09);
        repeat (3) @(posedge clk);
        chk("hdr tx on", 8'(h0 + 1), 8'(n_htx));
        chk("enable on", 8'h01, {7'h0, link_enable});
        h0 = n_hrx;
        wr(SLFC_ADDR_CTRL, 8'h08);
        repeat (3) @(posedge clk);
        chk("hdr rx arm", 8'(h0 + 1), 8'(n_hrx));
        for (int c = 0; c < 4; c++) begin
            wr(SLFC_ADDR_CTRL, {2'b00, c[1:0], 4'h8});
            repeat (2) @(posedge clk);
            #1;
            chk("lin cfg", {5'h0, c != 1, c == 0 || c == 3, c == 3},
                {5'h0, crc_on, timeout_on, listen_on});
            chk("uart cfg", {6'h0, c == 1 || c == 2, c == 2},
                {6'h0, parity_en, parity_odd});
        end
        for (int c = 4; c < 8; c++) begin
            wr(SLFC_ADDR_CTRL, {5'h01, c[2:0]});
            repeat (2) @(posedge clk);
            #1 chk("uart en", {6'h0, c[1], c[0]}, {6'h0, uart_rx_en, uart_tx_en});
        end
        wr(SLFC_ADDR_LEN, 8'h53);
        wr(SLFC_ADDR_CTRL, 8'h0a);
        rchk("rx start len", SLFC_ADDR_LEN, 8'h03);
        rchk("rx busy", SLFC_ADDR_STAT, 8'h10);
        wr(SLFC_ADDR_LEN, 8'h77);
        rchk("rx held len", SLFC_ADDR_LEN, 8'h03);
        u_peer.rx_bytes(2, -1);
        rchk("rx count", SLFC_ADDR_LEN, 8'h23);
        u_peer.rx_bytes(2, -1);
        rchk("rx done len", SLFC_ADDR_LEN, 8'h33);
        rchk("rx done", SLFC_ADDR_STAT, 8'h01);
        wr(SLFC_ADDR_STAT, 8'h0f);
        wr(SLFC_ADDR_LEN, 8'h00);
        wr(SLFC_ADDR_CTRL, 8'h0a);
        u_peer.rx_bytes(1, -1);
        rchk("rx zero", SLFC_ADDR_STAT, 8'h01);
        rchk("rx zero len", SLFC_ADDR_LEN, 8'h00);
        wr(SLFC_ADDR_STAT, 8'h0f);
        wr(SLFC_ADDR_LEN, 8'h04);
        wr(SLFC_ADDR_CTRL, 8'h0a);
        u_peer.rx_bytes(4, 2);
        rchk("rx err", SLFC_ADDR_STAT, 8'h08);
        rchk("rx err len", SLFC_ADDR_LEN, 8'h24);
        wr(SLFC_ADDR_STAT, 8'h0f);
        wr(SLFC_ADDR_LEN, 8'hfc);
        wr(SLFC_ADDR_CTRL, 8'h0a);
        rchk("rx clamp", SLFC_ADDR_LEN, 8'h08);
        u_peer.rx_bytes(9, -1);
        rchk("rx clamp len", SLFC_ADDR_LEN, 8'h88);
        wr(SLFC_ADDR_STAT, 8'h0f);
        u_peer.gap = 30;
        wr(SLFC_ADDR_LEN, 8'h46);
        wr(SLFC_ADDR_CTRL, 8'h0b);
        rchk("tx start len", SLFC_ADDR_LEN, 8'h40);
        chk("tx not cks", 8'h00, {7'h0, tx_is_checksum});
        wait_idle();
        rchk("tx slow len", SLFC_ADDR_LEN, 8'h44);
        wr(SLFC_ADDR_STAT, 8'h0f);
        tx_run(8'h25, 0, -1, 8'h22, 8'h02, 3);
        tx_run(8'h05, 0, -1, 8'h00, 8'h02, 1);
        tx_run(8'h93, 2, -1, 8'h88, 8'h02, 9);
        tx_run(8'h30, 3, 1, 8'h31, 8'h08, 1);
        wr(SLFC_ADDR_CTRL, 8'h48);
        rchk("rev sel", SLFC_ADDR_CTRL, 8'h48);
        for (int c = 0; c < 4; c++) begin
            u_peer.id_ok(c[1:0]);
            rchk("id len", SLFC_ADDR_LEN, {lt[c], lt[c]});
            rchk("id ok", SLFC_ADDR_STAT, 8'h04);
            wr(SLFC_ADDR_STAT, 8'h0f);
        end
        wr(SLFC_ADDR_CTRL, 8'h0f);
        wr(SLFC_ADDR_CTRL, 8'h8f);
        rchk("swres on", SLFC_ADDR_CTRL, 8'h88);
        chk("swres uart", 8'h00, {6'h0, uart_rx_en, uart_tx_en});
        rchk("swres busy", SLFC_ADDR_STAT, 8'h20);
        repeat (8) @(posedge clk);
        rchk("swres off", SLFC_ADDR_CTRL, 8'h08);
        rchk("swres stat", SLFC_ADDR_STAT, 8'h00);
        tally_and_finish();
    end
endmodule // slfc_frame_ctrl_tb_top

// >>> verif/slfc_peer_model.sv
// Behavioural byte engine and remote node as seen by the frame control block.
`timescale 1ns/1ps
module slfc_peer_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Requests from the frame control
    input wire logic tx_byte_req,
    input wire logic tx_is_checksum,
    // Events towards the frame control
    output logic rx_byte_valid,
    output logic tx_byte_sent,
    output logic link_error,
    output logic hdr_id_ok,
    output logic [1:0] hdr_len_code
);
    int gap = 0;
    int tx_err_at = -1;
    int n_tx = 0;
    int n_cks = 0;

    initial begin
        rx_byte_valid = 1'b0;
        tx_byte_sent = 1'b0;
        link_error = 1'b0;
        hdr_id_ok = 1'b0;
        hdr_len_code = 2'h0;
    end

    // Sends data bytes then the checksum; an error aborts the frame.
    task automatic rx_bytes(input int n, input int err_at);
        for (int i = 0; i < n; i++) begin
            repeat (gap) @(posedge clk);
            @(posedge clk);
            if (i == err_at) begin
                link_error <= 1'b1;
            end else begin
                rx_byte_valid <= 1'b1;
            end
            @(posedge clk);
            link_error <= 1'b0;
            rx_byte_valid <= 1'b0;
            if (i == err_at) begin
                break;
            end
        end
    endtask

    // The length code is only meaningful beside the identifier pulse.
    task automatic id_ok(input logic [1:0] code);
        @(posedge clk);
        hdr_id_ok <= 1'b1;
        hdr_len_code <= code;
        @(posedge clk);
        hdr_id_ok <= 1'b0;
        hdr_len_code <= ~code;
    endtask

    // Serves byte requests; a checksum byte ends the frame.
    initial begin
        forever begin
            @(posedge clk);
            if (rstn === 1'b1 && tx_byte_req === 1'b1) begin
                repeat (gap) @(posedge clk);
                if (n_tx == tx_err_at) begin
                    link_error <= 1'b1;
                end else begin
                    tx_byte_sent <= 1'b1;
                    n_cks = n_cks + int'(tx_is_checksum === 1'b1);
                end
                n_tx = n_tx + 1;
                @(posedge clk);
                tx_byte_sent <= 1'b0;
                link_error <= 1'b0;
                repeat (2) @(posedge clk);
            end else begin
                n_tx = 0;
            end
        end
    end
endmodule // slfc_peer_model

// >>> verilog/slfc_frame_ctrl.sv
// Serial link frame control: control register, response length bookkeeping and command decode.
// How it works
// [R1] LIN 2.1 with tx length zero: the response is the checksum only.
// [R2] LIN 2.1 with rx length zero: first received byte is the checksum.
// [R3] LIN 2.1 lengths above eight are forced to eight when the command is taken.
// [R4] LIN 1.3 loads both lengths from the identifier code while idle; they show the cycle after identifier-ok.
// [R5] Rx response command clears tx length and holds rx length while busy.
// [R6] During rx response the tx length counts bytes received.
// [R7] Rx error stops reception, sets error, tx length keeps good byte count.
// [R8] Error-free rx sets rx-done after checksum; tx length equals rx length.
// [R9] Tx response command clears rx length and holds tx length while busy.
// [R10] During tx response the rx length counts bytes sent.
// [R11] Tx error stops sending, sets error, rx length keeps good byte count.
// [R12] Error-free tx sets tx-done after checksum; rx length equals tx length.
// [R13] Writing one to control bit 7 starts soft reset; bit clears itself after.
// [R14] Control bit 6 selects revision: zero LIN 2.1, one LIN 1.3.
// [R15] LIN configuration: standard, no CRC no timeout, no timeout, listen.
// [R16] UART configuration: no parity, even, odd, listen with no parity.
// [R17] Control bit 3 enables the controller in both modes.
// [R18] Commands are acted on only while the enable bit is set.
// [R19] LIN commands: rx header or abort, tx header, rx response, tx response.
// [R20] UART commands: 100 disables both, 11x enables rx, 1x1 enables tx.
// [R21] Soft reset idles the machines, aborts transfers and clears the command.
`timescale 1ns/1ps
module slfc_frame_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Byte engine events
    input wire logic rx_byte_valid,
    input wire logic tx_byte_sent,
    input wire logic link_error,
    input wire logic hdr_id_ok,
    input wire logic [1:0] hdr_len_code,
    // Byte engine requests
    output logic tx_byte_req,
    output logic tx_is_checksum,
    output logic hdr_tx_start,
    output logic hdr_rx_arm,
    // Mode outputs
    output logic link_enable,
    output logic crc_on,
    output logic timeout_on,
    output logic listen_on,
    output logic parity_en,
    output logic parity_odd,
    output logic uart_rx_en,
    output logic uart_tx_en
);
    import slfc_pkg::*;

    slfc_regs_t r_r;
    slfc_regs_t r_nxt;

    // Lengths above the maximum are forced down to it.
    function automatic logic [3:0] clamp_len(input logic [3:0] v);
        clamp_len = (v > SLFC_LEN_MAX) ? SLFC_LEN_MAX : v;
    endfunction

    // Length code carried in the identifier: 0 and 1 give two, 2 gives four, 3 gives eight.
    function automatic logic [3:0] code_len(input logic [1:0] c);
        case (c)
            2'h2: code_len = 4'h4;
            2'h3: code_len = 4'h8;
            default: code_len = 4'h2;
        endcase
    endfunction

    logic wr_ctrl;
    logic wr_len;
    logic wr_stat;
    logic legacy_revision_select;
    logic [2:0] cmd;
    logic [1:0] conf;
    logic cmd_ok;

    always_comb begin
        wr_ctrl = reg_wr && (reg_addr == SLFC_ADDR_CTRL);
        wr_len = reg_wr && (reg_addr == SLFC_ADDR_LEN);
        wr_stat = reg_wr && (reg_addr == SLFC_ADDR_STAT);
        legacy_revision_select = r_r.ctrl[SLFC_CTRL_REV];
        cmd = reg_wdata[2:0];
        // A control write refused during soft reset must not move the mode outputs either.
        conf = r_nxt_conf(r_r.ctrl, reg_wdata, wr_ctrl && !r_r.st[3]);
        cmd_ok = wr_ctrl && reg_wdata[SLFC_CTRL_ENA] && !reg_wdata[SLFC_CTRL_SWRES]
            && !r_r.st[3];
    end

    function automatic logic [1:0] r_nxt_conf(input logic [7:0] c, input logic [7:0] w,
                                              input logic we);
        r_nxt_conf = we ? w[SLFC_CTRL_CONF_LSB +: 2] : c[SLFC_CTRL_CONF_LSB +: 2];
    endfunction

    always_comb begin
        r_nxt = r_r;
        r_nxt.hdr_tx = 1'b0;
        r_nxt.hdr_rx = 1'b0;
        // Read data stands only in the cycle after the read strobe.
        r_nxt.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                SLFC_ADDR_CTRL: r_nxt.rdata = r_r.ctrl;
                SLFC_ADDR_LEN: r_nxt.rdata = {r_r.txl, r_r.rxl};
                SLFC_ADDR_STAT: r_nxt.rdata = {2'h0, r_r.st[3],
                    (r_r.st[1] || r_r.st[2]), r_r.err, r_r.idok, r_r.txok, r_r.rxok};
                default: r_nxt.rdata = 8'h00;
            endcase
        end

        // Status flags clear on a written one; a set in the same cycle wins below.
        if (wr_stat) begin
            if (reg_wdata[SLFC_STAT_RXOK]) r_nxt.rxok = 1'b0;
            if (reg_wdata[SLFC_STAT_TXOK]) r_nxt.txok = 1'b0;
            if (reg_wdata[SLFC_STAT_IDOK]) r_nxt.idok = 1'b0;
            if (reg_wdata[SLFC_STAT_ERR]) r_nxt.err = 1'b0;
        end

        // Lengths written by software only while no response is running.
        if (wr_len && r_r.st[0]) begin
            r_nxt.rxl = reg_wdata[SLFC_LEN_RX_LSB +: 4];
            r_nxt.txl = reg_wdata[SLFC_LEN_TX_LSB +: 4];
        end

        if (wr_ctrl && !r_r.st[3]) begin
            // [R17] enable and [R14] revision stored
            r_nxt.ctrl = reg_wdata;
            // [R13] soft reset start
            if (reg_wdata[SLFC_CTRL_SWRES]) begin
                r_nxt.st = SLFC_ST_SWRST;
                r_nxt.rst_cnt = SLFC_SWRST_CYCLES;
            end else if (!reg_wdata[SLFC_CTRL_ENA]) begin
                r_nxt.st = SLFC_ST_IDLE;
            end
        end

        // [R18] commands gated by enable
        if (cmd_ok) begin
            // [R19] LIN command decode
            case (cmd)
                SLFC_CMD_RX_HDR: begin
                    r_nxt.st = SLFC_ST_IDLE;
                    r_nxt.hdr_rx = 1'b1;
                end
                SLFC_CMD_TX_HDR: begin
                    r_nxt.st = SLFC_ST_IDLE;
                    r_nxt.hdr_tx = 1'b1;
                end
                SLFC_CMD_RX_RSP: begin
                    // [R5] rx command clears tx length
                    r_nxt.st = SLFC_ST_RXRSP;
                    r_nxt.txl = SLFC_LEN_RESET;
                    // [R3] clamp rx length
                    r_nxt.rxl = reg_wdata[SLFC_CTRL_REV] ? r_r.rxl : clamp_len(r_r.rxl);
                end
                SLFC_CMD_TX_RSP: begin
                    // [R9] tx command clears rx length
                    r_nxt.st = SLFC_ST_TXRSP;
                    r_nxt.rxl = SLFC_LEN_RESET;
                    // [R3] clamp tx length
                    r_nxt.txl = reg_wdata[SLFC_CTRL_REV] ? r_r.txl : clamp_len(r_r.txl);
                end
                default: r_nxt.st = SLFC_ST_IDLE;
            endcase
        end

        case (r_r.st)
            SLFC_ST_IDLE: begin
                // [R4] LIN 1.3 lengths from identifier
                if (hdr_id_ok) begin
                    if (legacy_revision_select) begin
                        r_nxt.rxl = code_len(hdr_len_code);
                        r_nxt.txl = code_len(hdr_len_code);
                    end
                    r_nxt.idok = 1'b1;
                end
            end
            SLFC_ST_RXRSP: begin
                // [R7] rx error stop
                if (link_error) begin
                    r_nxt.err = 1'b1;
                    r_nxt.st = SLFC_ST_IDLE;
                end else if (rx_byte_valid) begin
                    // [R2] zero length makes first byte the checksum
                    if (r_r.txl == r_r.rxl) begin
                        // [R8] rx done after checksum
                        r_nxt.rxok = 1'b1;
                        r_nxt.st = SLFC_ST_IDLE;
                    end else begin
                        // [R6] count received bytes
                        r_nxt.txl = r_r.txl + 4'h1;
                    end
                end
            end
            SLFC_ST_TXRSP: begin
                // [R11] tx error stop
                if (link_error) begin
                    r_nxt.err = 1'b1;
                    r_nxt.st = SLFC_ST_IDLE;
                end else if (tx_byte_sent) begin
                    // [R1] zero length sends checksum only
                    if (r_r.rxl == r_r.txl) begin
                        // [R12] tx done after checksum
                        r_nxt.txok = 1'b1;
                        r_nxt.st = SLFC_ST_IDLE;
                    end else begin
                        // [R10] count sent bytes
                        r_nxt.rxl = r_r.rxl + 4'h1;
                    end
                end
            end
            SLFC_ST_SWRST: begin
                // [R21] soft reset idles and clears command
                r_nxt.ctrl[2:0] = SLFC_CMD_RX_HDR;
                r_nxt.urx_en = 1'b0;
                r_nxt.utx_en = 1'b0;
                r_nxt.rst_cnt = r_r.rst_cnt - 3'h1;
                if (r_r.rst_cnt == 3'h1) begin
                    // [R13] bit clears itself at the end
                    r_nxt.ctrl[SLFC_CTRL_SWRES] = 1'b0;
                    r_nxt.st = SLFC_ST_IDLE;
                end
            end
            default: r_nxt.st = SLFC_ST_IDLE;
        endcase

        // Mode outputs follow the control value being stored.
        r_nxt.ena = r_nxt.ctrl[SLFC_CTRL_ENA];
        // [R15] LIN configuration decode
        r_nxt.crc_on = (conf != SLFC_CONF_ALT1);
        r_nxt.tmo_on = (conf == SLFC_CONF_STD) || (conf == SLFC_CONF_LISTEN);
        r_nxt.listen = (conf == SLFC_CONF_LISTEN);
        // [R16] UART parity decode
        r_nxt.par_en = (conf == SLFC_CONF_ALT1) || (conf == SLFC_CONF_ALT2);
        r_nxt.par_odd = (conf == SLFC_CONF_ALT2);
        // [R20] UART byte enables
        if (cmd_ok && cmd[2]) begin
            r_nxt.urx_en = cmd[1];
            r_nxt.utx_en = cmd[0];
        end else if (!r_nxt.ena) begin
            r_nxt.urx_en = 1'b0;
            r_nxt.utx_en = 1'b0;
        end
        // The engine is told which byte is the checksum so no count is needed there.
        r_nxt.tx_req = (r_nxt.st == SLFC_ST_TXRSP);
        r_nxt.tx_cks = (r_nxt.st == SLFC_ST_TXRSP) && (r_nxt.rxl == r_nxt.txl);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_r <= '{st: SLFC_ST_IDLE, ctrl: SLFC_CTRL_RESET, rxl: SLFC_LEN_RESET,
                     txl: SLFC_LEN_RESET, rst_cnt: 3'h0, rdata: 8'h00, crc_on: 1'b1,
                     tmo_on: 1'b1, default: 1'b0};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign reg_rdata = r_r.rdata;
    assign tx_byte_req = r_r.tx_req;
    assign tx_is_checksum = r_r.tx_cks;
    assign hdr_tx_start = r_r.hdr_tx;
    assign hdr_rx_arm = r_r.hdr_rx;
    assign link_enable = r_r.ena;
    assign crc_on = r_r.crc_on;
    assign timeout_on = r_r.tmo_on;
    assign listen_on = r_r.listen;
    assign parity_en = r_r.par_en;
    assign parity_odd = r_r.par_odd;
    assign uart_rx_en = r_r.urx_en;
    assign uart_tx_en = r_r.utx_en;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_rx_cmd;
        reg_wr && reg_addr == SLFC_ADDR_CTRL && reg_wdata[3:0] == 4'ha && r_r.st[0]
            && !reg_wdata[SLFC_CTRL_SWRES] && !reg_wdata[SLFC_CTRL_REV];
    endsequence

    sequence s_tx_cmd;
        reg_wr && reg_addr == SLFC_ADDR_CTRL && reg_wdata[3:0] == 4'hb && r_r.st[0]
            && !reg_wdata[SLFC_CTRL_SWRES] && !reg_wdata[SLFC_CTRL_REV];
    endsequence

    chk_rx_cmd_len: assert property ( // [R5] [R3]
        s_rx_cmd |=> r_r.st == SLFC_ST_RXRSP && r_r.txl == 4'h0 && r_r.rxl <= 4'h8)
        else $error("rx command did not clear or clamp lengths");
    chk_tx_cmd_len: assert property ( // [R9] [R3]
        s_tx_cmd |=> r_r.st == SLFC_ST_TXRSP && r_r.rxl == 4'h0 && r_r.txl <= 4'h8)
        else $error("tx command did not clear or clamp lengths");
    chk_rx_hold_len: assert property ( // [R5]
        r_r.st[1] && $past(r_r.st[1]) |-> $stable(r_r.rxl))
        else $error("rx length moved during rx response");
    chk_rx_count_step: assert property ( // [R6]
        r_r.st[1] && rx_byte_valid && !link_error && r_r.txl != r_r.rxl
        |=> r_r.txl == $past(r_r.txl) + 4'h1)
        else $error("rx byte not counted");
    chk_rx_done_eq: assert property ( // [R8]
        $rose(r_r.rxok) && !$past(wr_ctrl) |-> r_r.txl == r_r.rxl && r_r.st[0])
        else $error("rx done with unequal lengths");
    chk_tx_done_eq: assert property ( // [R12]
        $rose(r_r.txok) && !$past(wr_ctrl) |-> r_r.rxl == r_r.txl && r_r.st[0])
        else $error("tx done with unequal lengths");
    chk_err_stop: assert property ( // [R7] [R11]
        (r_r.st[1] || r_r.st[2]) && link_error && !wr_ctrl
        |=> r_r.err && r_r.st[0])
        else $error("error did not stop response");
    chk_tx_count_hold: assert property ( // [R10]
        r_r.st[2] && !tx_byte_sent && !wr_ctrl
        |=> $stable(r_r.rxl) && $stable(r_r.txl))
        else $error("tx lengths moved while no byte was sent");
    chk_swrst_clear: assert property ( // [R13] [R21]
        r_r.st == SLFC_ST_SWRST && r_r.rst_cnt == 3'h4
        |-> ##3 (r_r.st[3] && r_r.rst_cnt == 3'h1) ##1 (r_r.st[0]
        && !r_r.ctrl[SLFC_CTRL_SWRES] && r_r.ctrl[2:0] == 3'h0))
        else $error("soft reset did not finish in four cycles");
    chk_disabled_cmd: assert property ( // [R18] [R17]
        reg_wr && reg_addr == SLFC_ADDR_CTRL && !reg_wdata[SLFC_CTRL_ENA]
        |=> !r_r.st[1] && !r_r.st[2] && !uart_rx_en && !uart_tx_en)
        else $error("command acted while disabled");
    chk_legacy_revision_select_len: assert property ( // [R4]
        r_r.st[0] && hdr_id_ok && legacy_revision_select && !wr_len && !wr_ctrl
        |=> r_r.rxl == r_r.txl && r_r.idok)
        else $error("LIN 1.3 lengths differ");
    chk_conf_decode: assert property ( // [R15] [R16]
        r_r.ctrl[5:4] == 2'h1 && $stable(r_r.ctrl)
        |-> !crc_on && !timeout_on && parity_en && !parity_odd)
        else $error("configuration decode wrong");

endmodule // slfc_frame_ctrl

// >>> verilog/slfc_pkg.sv
// Constants, state encoding and state record of the serial link frame control block.
package slfc_pkg;

    // Register offsets on the plain register port.
    localparam logic [1:0] SLFC_ADDR_CTRL = 2'h0;
    localparam logic [1:0] SLFC_ADDR_LEN = 2'h1;
    localparam logic [1:0] SLFC_ADDR_STAT = 2'h2;

    // Field positions of serial_link_control.
    localparam int SLFC_CTRL_SWRES = 7;
    localparam int SLFC_CTRL_REV = 6;
    localparam int SLFC_CTRL_CONF_LSB = 4;
    localparam int SLFC_CTRL_ENA = 3;

    // Field positions of data_length_register: rx length low, tx length high.
    localparam int SLFC_LEN_RX_LSB = 0;
    localparam int SLFC_LEN_TX_LSB = 4;

    // Field positions of the status register.
    localparam int SLFC_STAT_RXOK = 0;
    localparam int SLFC_STAT_TXOK = 1;
    localparam int SLFC_STAT_IDOK = 2;
    localparam int SLFC_STAT_ERR = 3;
    localparam int SLFC_STAT_BUSY = 4;
    localparam int SLFC_STAT_SWRST = 5;

    // Values after reset and counts.
    localparam logic [7:0] SLFC_CTRL_RESET = 8'h00;
    localparam logic [3:0] SLFC_LEN_RESET = 4'h0;
    localparam logic [3:0] SLFC_LEN_MAX = 4'h8;
    localparam logic [2:0] SLFC_SWRST_CYCLES = 3'h4;

    // Command codes.
    localparam logic [2:0] SLFC_CMD_RX_HDR = 3'h0;
    localparam logic [2:0] SLFC_CMD_TX_HDR = 3'h1;
    localparam logic [2:0] SLFC_CMD_RX_RSP = 3'h2;
    localparam logic [2:0] SLFC_CMD_TX_RSP = 3'h3;

    // Configuration codes.
    localparam logic [1:0] SLFC_CONF_STD = 2'h0;
    localparam logic [1:0] SLFC_CONF_ALT1 = 2'h1;
    localparam logic [1:0] SLFC_CONF_ALT2 = 2'h2;
    localparam logic [1:0] SLFC_CONF_LISTEN = 2'h3;

    typedef enum logic [3:0] {
        SLFC_ST_IDLE = 4'b0001,
        SLFC_ST_RXRSP = 4'b0010,
        SLFC_ST_TXRSP = 4'b0100,
        SLFC_ST_SWRST = 4'b1000
    } slfc_state_t;

    typedef struct packed {
        slfc_state_t st;
        logic [7:0] ctrl;
        logic [3:0] rxl;
        logic [3:0] txl;
        logic rxok;
        logic txok;
        logic idok;
        logic err;
        logic [2:0] rst_cnt;
        logic [7:0] rdata;
        logic tx_req;
        logic tx_cks;
        logic hdr_tx;
        logic hdr_rx;
        logic crc_on;
        logic tmo_on;
        logic listen;
        logic par_en;
        logic par_odd;
        logic urx_en;
        logic utx_en;
        logic ena;
    } slfc_regs_t;

endpackage
